/* rtl/cfr_regs.sv */
// Clock tuning, sync edge position and full-scale range register bank
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "cfr_params.svh"

module cfr_regs (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [`CFR_ADDR_W-1:0] reg_addr_in,
  input wire logic [`CFR_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`CFR_DATA_W-1:0] sync_pos_in,
  input wire logic sync_pos_valid_in,
  output logic [`CFR_DATA_W-1:0] reg_rdata_out,
  output logic feedback_gain_high_out,
  output logic supply_noise_suppress_enable_out,
  output logic [1:0] sample_clock_delay_onehot_out,
  output logic [15:0] full_scale_adjust_chan_a_out,
  output logic [15:0] full_scale_adjust_chan_b_out
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [3:0] cfr_decode(input logic [`CFR_ADDR_W-1:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (addr)
      `CFR_OFF_CLK_TUNE: sel = cfr_pkg::CFR_SEL_CLK_TUNE;
      `CFR_OFF_SYNC_POS: sel = cfr_pkg::CFR_SEL_SYNC_POS;
      `CFR_OFF_FS_A: sel = cfr_pkg::CFR_SEL_FS_A;
      `CFR_OFF_FS_B: sel = cfr_pkg::CFR_SEL_FS_B;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction

  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic [7:0] clk_tune_q;
  logic [`CFR_DATA_W-1:0] sync_pos_q;
  logic [`CFR_DATA_W-1:0] sync_pos_s1_q;
  logic [`CFR_DATA_W-1:0] sync_pos_s2_q;
  logic sync_vld_s1_q;
  logic sync_vld_s2_q;
  cfr_pkg::cfr_fs_code_t fs_a_q;
  cfr_pkg::cfr_fs_code_t fs_b_q;
  logic [`CFR_DATA_W-1:0] rdata_d;

  assign wr_sel = reg_wr_in ? cfr_decode(reg_addr_in) : 4'h0;
  assign rd_sel = reg_rd_in ? cfr_decode(reg_addr_in) : 4'h0;

  // ****************************************************************
  // Clock tuning register
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      clk_tune_q <= `CFR_RST_CLK_TUNE;
    end else if (wr_sel[0]) begin
      // Reserved bits masked; delay code kept as written
      clk_tune_q <= reg_wdata_in[7:0] & `CFR_CLK_TUNE_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      feedback_gain_high_out <= 1'b1;
      supply_noise_suppress_enable_out <= 1'b0;
      sample_clock_delay_onehot_out <= 2'h1;
    end else begin
      feedback_gain_high_out <= clk_tune_q[`CFR_BIT_FB_GAIN];
      supply_noise_suppress_enable_out <= clk_tune_q[`CFR_BIT_NOISE_SUPPR];
      sample_clock_delay_onehot_out <= clk_tune_q[1:0];
    end
  end

  // ****************************************************************
  // Sync edge position capture
  // ****************************************************************
  // Capture comes from the analog detector, outside this clock domain
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sync_pos_s1_q <= `CFR_RST_SYNC_POS;
      sync_pos_s2_q <= `CFR_RST_SYNC_POS;
      sync_vld_s1_q <= 1'b0;
      sync_vld_s2_q <= 1'b0;
    end else begin
      sync_pos_s1_q <= sync_pos_in;
      sync_pos_s2_q <= sync_pos_s1_q;
      sync_vld_s1_q <= sync_pos_valid_in;
      sync_vld_s2_q <= sync_vld_s1_q;
    end
  end

  // Bus writes never touch this status
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sync_pos_q <= `CFR_RST_SYNC_POS;
    end else if (sync_vld_s2_q) begin
      sync_pos_q <= sync_pos_s2_q;
    end
  end

  // ****************************************************************
  // Full-scale range registers
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      fs_a_q <= `CFR_RST_FS;
    end else if (wr_sel[2]) begin
      fs_a_q <= reg_wdata_in[15:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      fs_b_q <= `CFR_RST_FS;
    end else if (wr_sel[3]) begin
      fs_b_q <= reg_wdata_in[15:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      full_scale_adjust_chan_a_out <= `CFR_RST_FS;
      full_scale_adjust_chan_b_out <= `CFR_RST_FS;
    end else begin
      full_scale_adjust_chan_a_out <= fs_a_q;
      full_scale_adjust_chan_b_out <= fs_b_q;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_d = '0;
    unique case (rd_sel)
      4'h1: rdata_d = {16'h0000, clk_tune_q};
      4'h2: rdata_d = sync_pos_q;
      4'h4: rdata_d = {8'h00, fs_a_q};
      4'h8: rdata_d = {8'h00, fs_b_q};
      default: rdata_d = '0;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= rdata_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reserved_bits_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (clk_tune_q & ~`CFR_CLK_TUNE_MASK) == 8'h00) else $error("Reserved tuning bits set");

  tune_reset_value_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> clk_tune_q == `CFR_RST_CLK_TUNE) else $error("Tuning reset value wrong");

  gain_follows_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[0] ##1 !wr_sel[0] |=> feedback_gain_high_out == $past(reg_wdata_in[4], 2))
    else $error("Gain output mismatch");

  suppress_follows_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ##1 supply_noise_suppress_enable_out == $past(clk_tune_q[2])) else $error("Suppress output mismatch");

  delay_code_kept_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[0] |=> clk_tune_q[1:0] == $past(reg_wdata_in[1:0])) else $error("Delay code altered");

  sync_pos_ro_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !sync_vld_s2_q |=> $stable(sync_pos_q)) else $error("Sync status changed without capture");

  sync_read_back_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rd_sel[1] |=> reg_rdata_out == $past(sync_pos_q)) else $error("Sync status readback wrong");

  fs_a_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[2] |=> ##1 full_scale_adjust_chan_a_out == $past(reg_wdata_in[15:0], 2))
    else $error("Channel A range not applied");

  fs_b_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[3] |=> ##1 full_scale_adjust_chan_b_out == $past(reg_wdata_in[15:0], 2))
    else $error("Channel B range not applied");

  unmapped_reads_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && cfr_decode(reg_addr_in) == 4'h0 |=> reg_rdata_out == '0) else $error("Unmapped read nonzero");

  // ****************************************************************
  // Reset value checks
  // ****************************************************************
  gain_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> feedback_gain_high_out == 1'b1)
    else $error("Gain reset value wrong");

  suppress_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> supply_noise_suppress_enable_out == 1'b0)
    else $error("Suppress reset value wrong");

  delay_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> sample_clock_delay_onehot_out == 2'h1)
    else $error("Delay reset value wrong");

  fs_a_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> fs_a_q == `CFR_RST_FS && full_scale_adjust_chan_a_out == `CFR_RST_FS)
    else $error("Channel A range reset value wrong");

  fs_b_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> fs_b_q == `CFR_RST_FS && full_scale_adjust_chan_b_out == `CFR_RST_FS)
    else $error("Channel B range reset value wrong");

  sync_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> sync_pos_q == `CFR_RST_SYNC_POS)
    else $error("Sync status reset value wrong");

  rdata_reset_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> reg_rdata_out == '0)
    else $error("Read data not cleared by reset");

  // ****************************************************************
  // Hold and follow checks
  // ****************************************************************
  gain_out_tracks_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    1'b1 |=> feedback_gain_high_out == $past(clk_tune_q[`CFR_BIT_FB_GAIN]))
    else $error("Gain output does not track register");

  delay_out_tracks_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    1'b1 |=> sample_clock_delay_onehot_out == $past(clk_tune_q[1:0]))
    else $error("Delay output does not track register");

  fs_a_tracks_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    1'b1 |=> full_scale_adjust_chan_a_out == $past(fs_a_q))
    else $error("Channel A output does not track register");

  fs_b_tracks_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    1'b1 |=> full_scale_adjust_chan_b_out == $past(fs_b_q))
    else $error("Channel B output does not track register");

  tune_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !wr_sel[0] |=> $stable(clk_tune_q))
    else $error("Tuning register changed without write");

  fs_a_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !wr_sel[2] |=> $stable(fs_a_q))
    else $error("Channel A range changed without write");

  fs_b_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !wr_sel[3] |=> $stable(fs_b_q))
    else $error("Channel B range changed without write");

  sync_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    sync_vld_s2_q |=> sync_pos_q == $past(sync_pos_s2_q))
    else $error("Sync status not loaded on capture");

  sync_write_ignored_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[1] && !sync_vld_s2_q |=> $stable(sync_pos_q))
    else $error("Sync status written by bus");

  // ****************************************************************
  // Read-back checks
  // ****************************************************************
  tune_readback_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rd_sel[0] |=> reg_rdata_out == {16'h0000, $past(clk_tune_q)})
    else $error("Tuning readback wrong");

  fs_a_readback_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rd_sel[2] |=> reg_rdata_out == {8'h00, $past(fs_a_q)})
    else $error("Channel A range readback wrong");

  fs_b_readback_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rd_sel[3] |=> reg_rdata_out == {8'h00, $past(fs_b_q)})
    else $error("Channel B range readback wrong");

  read_idle_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("Read data outside read cycle");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  tune_write_cov: cover property (@(posedge mclk_in) disable iff (sys_rst_in) wr_sel[0] ##1 rd_sel[0]);
  fs_min_code_cov: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_sel[2] && reg_wdata_in[15:0] == `CFR_FS_MIN_REC);
  sync_capture_cov: cover property (@(posedge mclk_in) disable iff (sys_rst_in) sync_vld_s2_q ##1 rd_sel[1]);
  fs_pair_write_cov: cover property (@(posedge mclk_in) disable iff (sys_rst_in) wr_sel[2] ##1 wr_sel[3]);
  mid_reset_cov: cover property (@(posedge mclk_in) !sys_rst_in ##1 sys_rst_in);

endmodule

/* rtl/cfr_params.svh */
// Register offsets, field positions, reset values and sizes for the clock and full-scale bank
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH

`define CFR_ADDR_W 12
`define CFR_DATA_W 24

`define CFR_OFF_CLK_TUNE 12'h02B
`define CFR_OFF_SYNC_POS 12'h02C
`define CFR_OFF_FS_A 12'h030
`define CFR_OFF_FS_B 12'h032

`define CFR_RST_CLK_TUNE 8'h11
`define CFR_RST_SYNC_POS 24'h000000
`define CFR_RST_FS 16'hA000

`define CFR_CLK_TUNE_MASK 8'h17
`define CFR_BIT_FB_GAIN 4
`define CFR_BIT_NOISE_SUPPR 2
`define CFR_FS_MIN_REC 16'h2000

`endif

/* rtl/cfr_pkg.sv */
// Types for the clock and full-scale register bank
package cfr_pkg;

  typedef enum logic [3:0] {
    CFR_SEL_CLK_TUNE = 4'h1,
    CFR_SEL_SYNC_POS = 4'h2,
    CFR_SEL_FS_A = 4'h4,
    CFR_SEL_FS_B = 4'h8
  } cfr_sel_t;

  typedef logic [15:0] cfr_fs_code_t;

endpackage

/* dv/cfr_regs_bench.sv */
// Self-checking bench for the clock and full-scale register bank
`timescale 1ns/100ps
`include "cfr_params.svh"

module cfr_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [23:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [23:0] spos = 24'h000000;
  logic spos_vld = 1'b0;
  logic [23:0] rdata;
  logic gain, supp;
  logic [1:0] dly;
  logic [15:0] fsa, fsb;
  int fails = 0;
  int num_checks = 0;

  cfr_regs uut (.mclk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .sync_pos_in(spos), .sync_pos_valid_in(spos_vld), .reg_rdata_out(rdata),
    .feedback_gain_high_out(gain), .supply_noise_suppress_enable_out(supp),
    .sample_clock_delay_onehot_out(dly), .full_scale_adjust_chan_a_out(fsa), .full_scale_adjust_chan_b_out(fsb));

  always #12.5 clk = ~clk;

  // ********************
  // Bus and compare tasks
  // ********************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands one cycle, then returns to zero
  task automatic rd_chk(input logic [11:0] a, input logic [23:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
    #1 chk(rdata, 24'h000000);
  endtask

  task automatic outs(input logic g, input logic s, input logic [1:0] dl, input logic [15:0] a, input logic [15:0] b);
    chk({23'h0, gain}, {23'h0, g});
    chk({23'h0, supp}, {23'h0, s});
    chk({22'h0, dly}, {22'h0, dl});
    chk({8'h0, fsa}, {8'h0, a});
    chk({8'h0, fsb}, {8'h0, b});
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    #1 outs(1'b1, 1'b0, 2'h1, 16'hA000, 16'hA000);
    rd_chk(`CFR_OFF_CLK_TUNE, 24'h000011);
    rd_chk(`CFR_OFF_FS_A, 24'h00A000);
    rd_chk(`CFR_OFF_FS_B, 24'h00A000);
    rd_chk(`CFR_OFF_SYNC_POS, 24'h000000);
  endtask

  task automatic t_tune;
    wr_reg(`CFR_OFF_CLK_TUNE, 24'hFFFFFF);
    rd_chk(`CFR_OFF_CLK_TUNE, 24'h000017);
    outs(1'b1, 1'b1, 2'h3, 16'hA000, 16'hA000);
    wr_reg(`CFR_OFF_CLK_TUNE, 24'h000002);
    rd_chk(`CFR_OFF_CLK_TUNE, 24'h000002);
    outs(1'b0, 1'b0, 2'h2, 16'hA000, 16'hA000);
  endtask

  task automatic t_fs;
    wr_reg(`CFR_OFF_FS_A, 24'h002000);
    wr_reg(`CFR_OFF_FS_B, 24'h00FFFF);
    rd_chk(`CFR_OFF_FS_A, 24'h002000);
    rd_chk(`CFR_OFF_FS_B, 24'h00FFFF);
    outs(1'b0, 1'b0, 2'h2, 16'h2000, 16'hFFFF);
    wr_reg(`CFR_OFF_FS_A, 24'hFF9234);
    rd_chk(`CFR_OFF_FS_A, 24'h009234);
    wr_reg(12'h031, 24'h00FFFF);
    wr_reg(12'h42B, 24'h0000FF);
    rd_chk(12'h031, 24'h000000);
    rd_chk(12'h42B, 24'h000000);
    rd_chk(`CFR_OFF_CLK_TUNE, 24'h000002);
    outs(1'b0, 1'b0, 2'h2, 16'h9234, 16'hFFFF);
  endtask

  // Write then read with no gap between strobes
  task automatic t_b2b;
    @(posedge clk);
    wr <= 1'b1; addr <= `CFR_OFF_CLK_TUNE; wdata <= 24'h000015;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, 24'h000015);
    outs(1'b1, 1'b1, 2'h1, 16'h9234, 16'hFFFF);
  endtask

  // Sync position ignores bus writes and loads only from a capture
  task automatic t_sync;
    wr_reg(`CFR_OFF_SYNC_POS, 24'h555555);
    rd_chk(`CFR_OFF_SYNC_POS, 24'h000000);
    @(posedge clk);
    spos <= 24'hABCDEF; spos_vld <= 1'b1;
    repeat (4) @(posedge clk);
    spos_vld <= 1'b0;
    repeat (3) @(posedge clk);
    spos <= 24'h123456;
    rd_chk(`CFR_OFF_SYNC_POS, 24'hABCDEF);
  endtask

  // Reset in mid-run after writes and a capture
  task automatic t_rerst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 outs(1'b1, 1'b0, 2'h1, 16'hA000, 16'hA000);
    rd_chk(`CFR_OFF_CLK_TUNE, 24'h000011);
    rd_chk(`CFR_OFF_SYNC_POS, 24'h000000);
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(2000 * 25);
    fails++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tune();
    t_fs();
    t_b2b();
    t_sync();
    t_rerst();
    close_out();
  end
endmodule
